// [inc/ubc_pkg.sv]
package ubc_pkg;
    localparam logic [31:0] OUT_CS_ADDR = 32'h8000_0014;
    localparam logic [31:0] IN_CS_ADDR = 32'h8000_0018;
    localparam logic [31:0] MASK_ADDR = 32'h8000_0040;
    localparam logic [31:0] IRQ_ADDR = 32'h8000_0044;
    localparam int OUT_RFS = 0;
    localparam int OUT_RPC = 1;
    localparam int OUT_RPE = 2;
    localparam int OUT_SST = 3;
    localparam int OUT_FST = 4;
    localparam int OUT_RNE = 5;
    localparam int IN_TFS = 0;
    localparam int IN_TPC = 1;
    localparam int IN_TPE = 2;
    localparam int IN_TUR = 3;
    localparam int IN_SST = 4;
    localparam int IN_FST = 5;
    localparam int MASK_RIM = 0;
    localparam int MASK_TIM = 1;
    localparam int IRQ_RIR = 1;
    localparam int IRQ_TIR = 2;
    localparam logic [4:0] RX_DEPTH = 5'h14;
    localparam logic [4:0] RX_SVC_LEVEL = 5'h0c;
    localparam logic [4:0] TX_SVC_LEVEL = 5'h08;
    localparam logic [4:0] CNT_EMPTY = 5'h00;
    localparam logic [7:0] REG_RESET = 8'h00;
    typedef enum logic [1:0] {
        HS_NONE = 2'h0,
        HS_ACK = 2'h1,
        HS_NAK = 2'h2,
        HS_STALL = 2'h3
    } ubc_hs_t;
    typedef enum logic [1:0] {
        ST_RUN = 2'h0,
        ST_ARM = 2'h1,
        ST_HALT = 2'h3
    } ubc_stall_t;
    typedef struct packed {
        logic out_token;
        logic in_token;
        logic out_done;
        logic out_bad;
        logic out_oversize;
        logic in_done;
        logic in_noack;
        logic in_underrun;
        logic busy;
        logic [4:0] rx_count;
        logic [4:0] tx_count;
    } ubc_link_in_t;
    typedef struct packed {
        ubc_hs_t out_hs;
        ubc_hs_t in_hs;
        logic corrupt_crc;
        logic tx_flush;
        logic out_toggle_clr;
        logic in_toggle_clr;
    } ubc_link_out_t;
endpackage

// [design/ubc_bulk_ctrl.sv]
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/10ps
module ubc_bulk_ctrl (
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic [31:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire ubc_pkg::ubc_link_in_t link_in,
    output ubc_pkg::ubc_link_out_t link_out
);
    default clocking @(posedge core_clk_in);
    endclocking
    default disable iff (reset_in);

    ubc_pkg::ubc_link_in_t ev;
    logic ack_q;
    logic wr_go;
    logic rd_go;
    logic w_out;
    logic w_in;
    logic w_mask;
    logic w_irq;
    logic [7:0] wdat;
    logic [31:0] rdata_q;
    logic rpc_q;
    logic rpe_q;
    logic tpc_q;
    logic tpe_q;
    logic tur_q;
    logic rir_q;
    logic tir_q;
    logic [1:0] mask_q;
    logic [1:0] fst_q;
    logic [1:0] sst_q;
    logic [1:0] fst_wr;
    logic [1:0] fst_val;
    logic [1:0] sst_clr;
    logic [1:0] sst_set;
    logic [1:0] force_halt;
    logic [1:0] tok;
    logic [1:0] halt;
    logic [1:0] tgl_q;
    ubc_pkg::ubc_stall_t st_q [2];
    ubc_pkg::ubc_hs_t out_hs_q;
    ubc_pkg::ubc_hs_t in_hs_q;
    logic crc_q;
    logic flush_q;
    logic rpc_clr;
    logic tpc_clr;
    logic [7:0] out_stat;
    logic [7:0] in_stat;
    logic [7:0] irq_stat;

    assign ev = link_in;

    // bus slave: one wait cycle per access
    assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_q;
    assign wr_go = avs_write_in & ack_q;
    assign rd_go = avs_read_in & ~ack_q;
    assign wdat = avs_writedata_in[7:0];
    assign w_out = wr_go & (avs_address_in == ubc_pkg::OUT_CS_ADDR);
    assign w_in = wr_go & (avs_address_in == ubc_pkg::IN_CS_ADDR);
    assign w_mask = wr_go & (avs_address_in == ubc_pkg::MASK_ADDR);
    assign w_irq = wr_go & (avs_address_in == ubc_pkg::IRQ_ADDR);
    assign avs_readdata_out = rdata_q;

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read_in | avs_write_in) & ~ack_q;
        end
    end

    // write side effects
    assign rpc_clr = w_out & wdat[ubc_pkg::OUT_RPC];
    assign tpc_clr = w_in & wdat[ubc_pkg::IN_TPC];
    assign fst_wr = {w_in, w_out};
    assign fst_val = {wdat[ubc_pkg::IN_FST], wdat[ubc_pkg::OUT_FST]};
    assign sst_clr[0] = w_out & wdat[ubc_pkg::OUT_SST];
    assign sst_clr[1] = w_in & wdat[ubc_pkg::IN_SST];
    assign force_halt = {1'b0, ev.out_oversize};
    assign tok = {ev.in_token, ev.out_token};

    // receive packet flags, set wins over clear
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            rpc_q <= 1'b0;
        end else if (ev.out_done) begin
            rpc_q <= 1'b1;
        end else if (rpc_clr) begin
            rpc_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            rpe_q <= 1'b0;
        end else if (ev.out_bad) begin
            rpe_q <= 1'b1;
        end else if (rpc_clr) begin
            rpe_q <= 1'b0;
        end
    end

    // transmit packet flags
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            tpc_q <= 1'b0;
        end else if (ev.in_done) begin
            tpc_q <= 1'b1;
        end else if (tpc_clr) begin
            tpc_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            tpe_q <= 1'b0;
        end else if (ev.in_noack) begin
            tpe_q <= 1'b1;
        end else if (tpc_clr) begin
            tpe_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            tur_q <= 1'b0;
        end else if (ev.in_underrun) begin
            tur_q <= 1'b1;
        end else if (tpc_clr) begin
            tur_q <= 1'b0;
        end
    end

    // interrupt masks and request bits
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            mask_q <= 2'h0;
        end else if (w_mask) begin
            mask_q <= {wdat[ubc_pkg::MASK_TIM], wdat[ubc_pkg::MASK_RIM]};
        end
    end

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            rir_q <= 1'b0;
        end else if (ev.out_done & ~mask_q[ubc_pkg::MASK_RIM]) begin
            rir_q <= 1'b1;
        end else if (w_irq & wdat[ubc_pkg::IRQ_RIR]) begin
            rir_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            tir_q <= 1'b0;
        end else if (ev.in_done & ~mask_q[ubc_pkg::MASK_TIM]) begin
            tir_q <= 1'b1;
        end else if (w_irq & wdat[ubc_pkg::IRQ_TIR]) begin
            tir_q <= 1'b0;
        end
    end

    // per endpoint stall control: 0 is OUT, 1 is IN
    for (genvar i = 0; i < 2; i++) begin : g_ep
        assign halt[i] = (st_q[i] == ubc_pkg::ST_HALT);
        assign sst_set[i] = force_halt[i] | (halt[i] & tok[i])
            | ((st_q[i] == ubc_pkg::ST_ARM) & fst_q[i] & ~ev.busy);

        always_ff @(posedge core_clk_in or posedge reset_in) begin
            if (reset_in) begin
                fst_q[i] <= 1'b0;
            end else if (fst_wr[i]) begin
                fst_q[i] <= fst_val[i];
            end
        end

        always_ff @(posedge core_clk_in or posedge reset_in) begin
            if (reset_in) begin
                sst_q[i] <= 1'b0;
            end else if (sst_set[i]) begin
                sst_q[i] <= 1'b1;
            end else if (sst_clr[i]) begin
                sst_q[i] <= 1'b0;
            end
        end

        always_ff @(posedge core_clk_in or posedge reset_in) begin
            if (reset_in) begin
                st_q[i] <= ubc_pkg::ST_RUN;
            end else begin
                case (st_q[i])
                    ubc_pkg::ST_RUN: begin
                        if (force_halt[i]) begin
                            st_q[i] <= ubc_pkg::ST_HALT;
                        end else if (fst_q[i]) begin
                            st_q[i] <= ubc_pkg::ST_ARM;
                        end
                    end
                    ubc_pkg::ST_ARM: begin
                        if (force_halt[i] || (fst_q[i] && !ev.busy)) begin
                            st_q[i] <= ubc_pkg::ST_HALT;
                        end else if (!fst_q[i]) begin
                            st_q[i] <= ubc_pkg::ST_RUN;
                        end
                    end
                    ubc_pkg::ST_HALT: begin
                        if (!fst_q[i] && !sst_q[i]) begin
                            st_q[i] <= ubc_pkg::ST_RUN;
                        end
                    end
                    default: begin
                        st_q[i] <= ubc_pkg::ST_RUN;
                    end
                endcase
            end
        end

        always_ff @(posedge core_clk_in or posedge reset_in) begin
            if (reset_in) begin
                tgl_q[i] <= 1'b0;
            end else begin
                tgl_q[i] <= halt[i] & ~fst_q[i] & ~sst_q[i];
            end
        end
    end

    // token answers, stall ahead of nak
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            out_hs_q <= ubc_pkg::HS_NONE;
        end else if (force_halt[0] | (tok[0] & halt[0])) begin
            out_hs_q <= ubc_pkg::HS_STALL;
        end else if (tok[0]) begin
            out_hs_q <= rpc_q ? ubc_pkg::HS_NAK : ubc_pkg::HS_ACK;
        end else begin
            out_hs_q <= ubc_pkg::HS_NONE;
        end
    end

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            in_hs_q <= ubc_pkg::HS_NONE;
        end else if (tok[1] & halt[1]) begin
            in_hs_q <= ubc_pkg::HS_STALL;
        end else if (tok[1] & (tpc_q | (ev.tx_count == ubc_pkg::CNT_EMPTY))) begin
            in_hs_q <= ubc_pkg::HS_NAK;
        end else if (tok[1]) begin
            in_hs_q <= ubc_pkg::HS_ACK;
        end else begin
            in_hs_q <= ubc_pkg::HS_NONE;
        end
    end

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            crc_q <= 1'b0;
        end else begin
            crc_q <= ev.in_underrun;
        end
    end

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            flush_q <= 1'b0;
        end else begin
            flush_q <= sst_clr[1] & sst_q[1] & ~sst_set[1];
        end
    end

    assign link_out.out_hs = out_hs_q;
    assign link_out.in_hs = in_hs_q;
    assign link_out.corrupt_crc = crc_q;
    assign link_out.tx_flush = flush_q;
    assign link_out.out_toggle_clr = tgl_q[0];
    assign link_out.in_toggle_clr = tgl_q[1];

    // status images
    always_comb begin
        out_stat = ubc_pkg::REG_RESET;
        out_stat[ubc_pkg::OUT_RFS] = (ev.rx_count >= ubc_pkg::RX_SVC_LEVEL);
        out_stat[ubc_pkg::OUT_RPC] = rpc_q;
        out_stat[ubc_pkg::OUT_RPE] = rpe_q;
        out_stat[ubc_pkg::OUT_SST] = sst_q[0];
        out_stat[ubc_pkg::OUT_FST] = fst_q[0];
        out_stat[ubc_pkg::OUT_RNE] = (ev.rx_count != ubc_pkg::CNT_EMPTY);
        in_stat = ubc_pkg::REG_RESET;
        in_stat[ubc_pkg::IN_TFS] = (ev.tx_count <= ubc_pkg::TX_SVC_LEVEL);
        in_stat[ubc_pkg::IN_TPC] = tpc_q;
        in_stat[ubc_pkg::IN_TPE] = tpe_q;
        in_stat[ubc_pkg::IN_TUR] = tur_q;
        in_stat[ubc_pkg::IN_SST] = sst_q[1];
        in_stat[ubc_pkg::IN_FST] = fst_q[1];
        irq_stat = ubc_pkg::REG_RESET;
        irq_stat[ubc_pkg::IRQ_RIR] = rir_q;
        irq_stat[ubc_pkg::IRQ_TIR] = tir_q;
    end

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            rdata_q <= 32'h0;
        end else if (rd_go) begin
            case (avs_address_in)
                ubc_pkg::OUT_CS_ADDR: rdata_q <= {24'h0, out_stat};
                ubc_pkg::IN_CS_ADDR: rdata_q <= {24'h0, in_stat};
                ubc_pkg::MASK_ADDR: rdata_q <= {30'h0, mask_q};
                ubc_pkg::IRQ_ADDR: rdata_q <= {24'h0, irq_stat};
                default: rdata_q <= 32'h0;
            endcase
        end
    end

    // checks
    sequence s_arm_idle(int k);
        fst_q[k] && !ev.busy && st_q[k] == ubc_pkg::ST_ARM;
    endsequence
    sequence s_halt_exit(int k);
        halt[k] ##1 !halt[k];
    endsequence

    rfs_read_a: assert property (rd_go && avs_address_in == ubc_pkg::OUT_CS_ADDR |=>
        avs_readdata_out[ubc_pkg::OUT_RFS] == ($past(ev.rx_count) >= ubc_pkg::RX_SVC_LEVEL))
        else $error("rx service flag wrong");
    rpc_set_a: assert property (ev.out_done |=> rpc_q)
        else $error("rx complete not set");
    out_nak_a: assert property (tok[0] && rpc_q && !halt[0] && !force_halt[0] |=>
        out_hs_q == ubc_pkg::HS_NAK)
        else $error("OUT token not NAKed");
    rir_set_a: assert property (ev.out_done && !mask_q[0] |=> rir_q && rpc_q)
        else $error("rx request not raised");
    rpe_clr_a: assert property ($fell(rpc_q) && !$past(ev.out_bad) |-> !rpe_q)
        else $error("rx error outlived complete");
    oversize_a: assert property (ev.out_oversize |=>
        out_hs_q == ubc_pkg::HS_STALL && sst_q[0] && halt[0])
        else $error("oversize not stalled");
    out_arm_a: assert property (s_arm_idle(0) |=> halt[0] && sst_q[0])
        else $error("OUT stall not entered");
    hold_out_a: assert property (halt[0] && (fst_q[0] || sst_q[0]) |=> halt[0])
        else $error("OUT stall left early");
    hold_in_a: assert property (halt[1] && (fst_q[1] || sst_q[1]) |=> halt[1])
        else $error("IN stall left early");
    toggle_a: assert property (s_halt_exit(1) |-> tgl_q[1])
        else $error("IN toggle not restarted");
    rne_read_a: assert property (rd_go && avs_address_in == ubc_pkg::OUT_CS_ADDR |=>
        avs_readdata_out[ubc_pkg::OUT_RNE] == ($past(ev.rx_count) != ubc_pkg::CNT_EMPTY))
        else $error("rx not-empty wrong");
    tfs_read_a: assert property (rd_go && avs_address_in == ubc_pkg::IN_CS_ADDR |=>
        avs_readdata_out[ubc_pkg::IN_TFS] == ($past(ev.tx_count) <= ubc_pkg::TX_SVC_LEVEL))
        else $error("tx service flag wrong");
    in_nak_a: assert property (tok[1] && tpc_q && !halt[1] |=>
        in_hs_q == ubc_pkg::HS_NAK)
        else $error("IN token not NAKed");
    tpe_clr_a: assert property ($fell(tpc_q) && !$past(ev.in_noack) |->
        !tpe_q && (!tur_q || $past(ev.in_underrun)))
        else $error("tx error outlived complete");
    crc_cut_a: assert property (ev.in_underrun |=> crc_q && tur_q)
        else $error("underrun not marked");
    flush_a: assert property (flush_q |-> $past(sst_q[1]) && !sst_q[1])
        else $error("flush without stall clear");
    in_arm_a: assert property (s_arm_idle(1) ##1 tok[1] |=>
        in_hs_q == ubc_pkg::HS_STALL)
        else $error("IN stall not answered");
    zero_len_a: assert property (in_hs_q == ubc_pkg::HS_ACK |->
        $past(ev.tx_count) != ubc_pkg::CNT_EMPTY)
        else $error("zero-length IN data");
    rir_mask_a: assert property ($rose(rir_q) |-> rpc_q && !$past(mask_q[0]))
        else $error("rx request while masked");
    stall_wins_a: assert property (tok[0] && halt[0] && rpc_q |=>
        out_hs_q == ubc_pkg::HS_STALL)
        else $error("NAK beat STALL");
endmodule

// [testbench/ubc_host_model.sv]
`timescale 1ns/10ps
module ubc_host_model (
    input wire logic clk_in,
    input wire ubc_pkg::ubc_link_out_t link_out_in,
    output ubc_pkg::ubc_link_in_t link_in_out
);
    ubc_pkg::ubc_hs_t seen_out_hs;
    ubc_pkg::ubc_hs_t seen_in_hs;
    logic seen_crc;
    int n_flush = 0;
    int n_tog_out = 0;
    int n_tog_in = 0;

    initial link_in_out = '0;

    // counts the one-cycle pulses the controller hands to the serial side
    always @(posedge clk_in) begin
        if (link_out_in.tx_flush === 1'b1)
            n_flush++;
        if (link_out_in.out_toggle_clr === 1'b1)
            n_tog_out++;
        if (link_out_in.in_toggle_clr === 1'b1)
            n_tog_in++;
    end

    // one-cycle link event; pulse fields sit at struct bits 18 down to 11
    // 0 out token, 1 in token, 2 out done, 3 out bad, 4 oversize,
    // 5 in done, 6 no ack, 7 underrun; answers are caught one edge later
    task automatic ev(input int sel);
        @(posedge clk_in);
        link_in_out[18 - sel] <= 1'b1;
        @(posedge clk_in);
        link_in_out[18:11] <= 8'h00;
        #1;
        seen_out_hs = link_out_in.out_hs;
        seen_in_hs = link_out_in.in_hs;
        seen_crc = link_out_in.corrupt_crc;
    endtask

    task automatic levels(input logic busy_v, input logic [4:0] rx_v, input logic [4:0] tx_v);
        @(posedge clk_in);
        link_in_out.busy <= busy_v;
        link_in_out.rx_count <= rx_v;
        link_in_out.tx_count <= tx_v;
    endtask
endmodule

// [testbench/testbench.sv]
`timescale 1ns/10ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin bad_count++; \
    $display("CHECK FAILED at %0t got %h expected %h", $time, (a), (e)); end end
module testbench;
    logic core_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [31:0] avs_address_in;
    logic avs_read_in;
    logic avs_write_in;
    logic [31:0] avs_writedata_in;
    logic [31:0] avs_readdata_out;
    logic avs_waitrequest_out;
    ubc_pkg::ubc_link_in_t link_in;
    ubc_pkg::ubc_link_out_t link_out;
    int bad_count = 0;
    int num_checks = 0;
    logic [31:0] rv;
    logic [4:0] tbl [7] = '{5'h00, 5'h01, 5'h08, 5'h09, 5'h0b, 5'h0c, 5'h14};

    always #10 core_clk_in = ~core_clk_in;

    ubc_bulk_ctrl i_dut (
        .core_clk_in(core_clk_in),
        .reset_in(reset_in),
        .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in),
        .avs_write_in(avs_write_in),
        .avs_writedata_in(avs_writedata_in),
        .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out),
        .link_in(link_in),
        .link_out(link_out)
    );

    ubc_host_model i_host (
        .clk_in(core_clk_in),
        .link_out_in(link_out),
        .link_in_out(link_in)
    );

    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // one Avalon access held until waitrequest is seen low
    task automatic bus(input logic is_wr, input logic [31:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        avs_address_in <= a;
        avs_writedata_in <= {24'h000000, d};
        avs_write_in <= is_wr;
        avs_read_in <= !is_wr;
        do begin
            @(posedge core_clk_in);
        end while (avs_waitrequest_out !== 1'b0);
        rv = avs_readdata_out;
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
    endtask

    task automatic chk_rd(input logic [31:0] a, input logic [31:0] e);
        bus(1'b0, a, 8'h00);
        `CHK(rv, e)
    endtask

    // write, then trust only the second of two read-backs
    task automatic wr_chk(input logic [31:0] a, input logic [7:0] d, input logic [31:0] e);
        bus(1'b1, a, d);
        bus(1'b0, a, 8'h00);
        chk_rd(a, e);
    endtask

    task automatic tok(input int sel, input ubc_pkg::ubc_hs_t e);
        i_host.ev(sel);
        if (sel == 0)
            `CHK(i_host.seen_out_hs, e)
        else
            `CHK(i_host.seen_in_hs, e)
    endtask

    // about 320 cycles of traffic expected; far longer means a hang
    initial begin
        repeat (20000) @(posedge core_clk_in);
        bad_count++;
        close_out();
    end

    initial begin
        avs_address_in <= 32'h0;
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
        avs_writedata_in <= 32'h0;
        repeat (8) @(posedge core_clk_in);
        reset_in <= 1'b0;
        i_host.levels(1'b0, 5'h00, 5'h09);
        chk_rd(ubc_pkg::OUT_CS_ADDR, 32'h0);
        chk_rd(ubc_pkg::IN_CS_ADDR, 32'h0);
        chk_rd(ubc_pkg::MASK_ADDR, 32'h0);
        chk_rd(ubc_pkg::IRQ_ADDR, 32'h0);
        wr_chk(32'h8000_0020, 8'hff, 32'h0);
        for (int i = 0; i < 7; i++) begin
            i_host.levels(1'b0, tbl[i], tbl[i]);
            chk_rd(ubc_pkg::OUT_CS_ADDR,
                {26'h0, tbl[i] != 5'h00, 4'h0, tbl[i] >= 5'h0c});
            chk_rd(ubc_pkg::IN_CS_ADDR, {31'h0, tbl[i] <= 5'h08});
        end
        i_host.levels(1'b0, 5'h00, 5'h09);
        // receive side: error, completion, pending NAK, request and mask
        tok(0, ubc_pkg::HS_ACK);
        i_host.ev(3);
        i_host.ev(2);
        chk_rd(ubc_pkg::IRQ_ADDR, 32'h2);
        chk_rd(ubc_pkg::OUT_CS_ADDR, 32'h06);
        // software drains leftover bytes until not-empty drops
        for (int k = 3; k >= 0; k--) begin
            i_host.levels(1'b0, 5'(k), 5'h09);
            chk_rd(ubc_pkg::OUT_CS_ADDR, {26'h0, k != 0, 5'h06});
        end
        tok(0, ubc_pkg::HS_NAK);
        wr_chk(ubc_pkg::OUT_CS_ADDR, 8'h02, 32'h0);
        tok(0, ubc_pkg::HS_ACK);
        wr_chk(ubc_pkg::IRQ_ADDR, 8'h02, 32'h0);
        wr_chk(ubc_pkg::MASK_ADDR, 8'h01, 32'h1);
        i_host.ev(2);
        chk_rd(ubc_pkg::IRQ_ADDR, 32'h0);
        wr_chk(ubc_pkg::OUT_CS_ADDR, 8'h02, 32'h0);
        wr_chk(ubc_pkg::MASK_ADDR, 8'h00, 32'h0);
        // transmit side: underrun, missing ack, completion, empty fifo
        tok(1, ubc_pkg::HS_ACK);
        i_host.ev(7);
        `CHK(i_host.seen_crc, 1'b1)
        i_host.ev(6);
        i_host.ev(5);
        chk_rd(ubc_pkg::IN_CS_ADDR, 32'h0e);
        chk_rd(ubc_pkg::IRQ_ADDR, 32'h4);
        tok(1, ubc_pkg::HS_NAK);
        wr_chk(ubc_pkg::IN_CS_ADDR, 8'h02, 32'h0);
        wr_chk(ubc_pkg::IRQ_ADDR, 8'h04, 32'h0);
        i_host.levels(1'b0, 5'h00, 5'h00);
        tok(1, ubc_pkg::HS_NAK);
        i_host.levels(1'b0, 5'h00, 5'h09);
        // out force-stall while busy and with a completion pending
        i_host.ev(2);
        i_host.levels(1'b1, 5'h00, 5'h09);
        wr_chk(ubc_pkg::OUT_CS_ADDR, 8'h10, 32'h12);
        i_host.levels(1'b0, 5'h00, 5'h09);
        chk_rd(ubc_pkg::OUT_CS_ADDR, 32'h1a);
        tok(0, ubc_pkg::HS_STALL);
        wr_chk(ubc_pkg::OUT_CS_ADDR, 8'h00, 32'h0a);
        tok(0, ubc_pkg::HS_STALL);
        wr_chk(ubc_pkg::OUT_CS_ADDR, 8'h08, 32'h02);
        `CHK(i_host.n_tog_out, 1)
        tok(0, ubc_pkg::HS_NAK);
        wr_chk(ubc_pkg::OUT_CS_ADDR, 8'h02, 32'h0);
        wr_chk(ubc_pkg::IRQ_ADDR, 8'h02, 32'h0);
        // oversize out packet
        i_host.ev(4);
        `CHK(i_host.seen_out_hs, ubc_pkg::HS_STALL)
        chk_rd(ubc_pkg::OUT_CS_ADDR, 32'h08);
        tok(0, ubc_pkg::HS_STALL);
        wr_chk(ubc_pkg::OUT_CS_ADDR, 8'h08, 32'h0);
        `CHK(i_host.n_tog_out, 2)
        tok(0, ubc_pkg::HS_ACK);
        // in force-stall, clearing the two bits in both orders
        wr_chk(ubc_pkg::IN_CS_ADDR, 8'h20, 32'h30);
        tok(1, ubc_pkg::HS_STALL);
        wr_chk(ubc_pkg::IN_CS_ADDR, 8'h30, 32'h20);
        tok(1, ubc_pkg::HS_STALL);
        wr_chk(ubc_pkg::IN_CS_ADDR, 8'h00, 32'h10);
        wr_chk(ubc_pkg::IN_CS_ADDR, 8'h10, 32'h00);
        `CHK(i_host.n_flush, 2)
        `CHK(i_host.n_tog_in, 1)
        tok(1, ubc_pkg::HS_ACK);
        close_out();
    end
endmodule
